// ==== core/wdrs_pkg.sv ====
// Shared constants and types of the watchdog and reset cause block
package wdrs_pkg;
  // Register byte offsets
  localparam logic [7:0] WDRS_CTRL_OFF = 8'h60;
  localparam logic [7:0] WDRS_CAUSE_OFF = 8'h54;
  // Control field reset values
  localparam logic WDRS_WDE_RST = 1'b0;
  localparam logic [3:0] WDRS_PER_RST = 4'h0;
  // Unlock window length in system clock cycles
  localparam logic [2:0] WDRS_UNLOCK_CYCLES = 3'h4;
  localparam logic [2:0] WDRS_UNLOCK_LAST = 3'h1;
  // Shortest period is two to this power oscillator cycles
  localparam int WDRS_BASE_SHIFT = 11;
  localparam int WDRS_CNT_W = 20;
  // Highest defined period code; codes above it are reserved
  localparam logic [3:0] WDRS_PER_MAX = 4'h9;
  // Index of each pin input inside the synchroniser vector
  localparam int WDRS_SYNC_W = 5;
  localparam int WDRS_S_OSC = 0;
  localparam int WDRS_S_PIN = 1;
  localparam int WDRS_S_BOR = 2;
  localparam int WDRS_S_SCAN = 3;
  localparam int WDRS_S_FUSE = 4;

  // Control and status register layout, bit 7 first
  typedef struct packed {
    logic irq_flag;
    logic irq_en;
    logic per_hi;
    logic unlock;
    logic dog_sysreset_enable;
    logic [2:0] per_lo;
  } wdrs_ctrl_t;

  // Reset cause register layout, bit 7 first
  typedef struct packed {
    logic [2:0] pad;
    logic scan;
    logic dog;
    logic brown;
    logic pin;
    logic poweron;
  } wdrs_cause_t;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } wdrs_bus_t;

  // Control value after reset; a system reset keeps the reset enable
  localparam wdrs_ctrl_t WDRS_CTRL_RST = '{irq_flag: 1'b0, irq_en: 1'b0,
    per_hi: WDRS_PER_RST[3], unlock: 1'b0, dog_sysreset_enable: WDRS_WDE_RST, per_lo: WDRS_PER_RST[2:0]};
  // Cause value after power-on
  localparam wdrs_cause_t WDRS_CAUSE_POR = '{pad: 3'h0, scan: 1'b0, dog: 1'b0,
    brown: 1'b0, pin: 1'b0, poweron: 1'b1};
endpackage : wdrs_pkg

// ==== core/wdrs_top.sv ====
// Watchdog timer with protected set-up and reset cause status register
// What this block does
// - Scan reset sets its cause flag
// - Watchdog reset sets its cause flag
// - Brown-out reset sets its cause flag
// - Pin reset sets its cause flag
// - Power-on flag cleared only by software
// - Interrupt-mode time-out sets interrupt flag
// - Vector or written one clears flag
// - Interrupt needs flag, enable, global enable
// - Enable bits and fuse select mode
// - Combined mode vector clears enable, flag
// - Unserviced second time-out resets system
// - Unlock bit self-clears four cycles later
// - Clearing reset enable, period need unlock
// - Reset cause flag holds reset enable
// - Period is 2048 cycles doubling per code
// - Counter counts synchronised slow oscillator edges
// - Restart clears counter
// - Reset pulse lasts one system cycle
// - Fuse locks enable one, interrupt zero
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/100ps
module wdrs_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire wdrs_pkg::wdrs_bus_t bus,
  output logic [7:0] rdata,
  input wire logic dog_osc_in,
  input wire logic pin_reset_in,
  input wire logic brownout_in,
  input wire logic scan_reset_in,
  input wire logic dog_always_on_fuse,
  input wire logic dog_restart,
  input wire logic cpu_global_irq_enable,
  input wire logic dog_vector_ack,
  output logic dog_irq,
  output logic dog_sysreset_pulse
);
  import wdrs_pkg::*;

  // Time-out limit for a period code; reserved codes use the longest period
  function automatic logic [WDRS_CNT_W-1:0] wdrs_limit(input logic [3:0] code);
    logic [3:0] c;
    c = (code > WDRS_PER_MAX) ? WDRS_PER_MAX : code;
    return WDRS_CNT_W'((64'h1 << (WDRS_BASE_SHIFT + int'(c))) - 64'h1);
  endfunction : wdrs_limit

  // Synchroniser stages and filtered levels of the pin inputs
  logic [WDRS_SYNC_W-1:0] s1_reg;
  logic [WDRS_SYNC_W-1:0] s2_reg;
  logic [WDRS_SYNC_W-1:0] s3_reg;
  logic [WDRS_SYNC_W-1:0] filt_reg;
  logic [WDRS_SYNC_W-1:0] filt_next;
  logic [WDRS_SYNC_W-1:0] agree;
  // Control, cause, counters
  wdrs_ctrl_t ctrl_reg;
  wdrs_ctrl_t ctrl_next;
  wdrs_cause_t cause_reg;
  wdrs_cause_t cause_next;
  logic [WDRS_CNT_W-1:0] cnt_reg;
  logic [WDRS_CNT_W-1:0] cnt_next;
  logic [2:0] unl_cnt_reg;
  logic [2:0] unl_cnt_next;
  // Output flops
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic irq_reg;
  logic irq_next;
  logic pulse_reg;

  // Decoded bus accesses
  wire logic wr_ctrl = bus.wr && (bus.addr == WDRS_CTRL_OFF);
  wire logic wr_cause = bus.wr && (bus.addr == WDRS_CAUSE_OFF);
  wire logic rd_ctrl = bus.rd && (bus.addr == WDRS_CTRL_OFF);
  wire logic rd_cause = bus.rd && (bus.addr == WDRS_CAUSE_OFF);
  wire wdrs_ctrl_t wd = wdrs_ctrl_t'(bus.wdata);

  // Filtered pin levels
  wire logic fuse = filt_reg[WDRS_S_FUSE];
  wire logic pin_rst = filt_reg[WDRS_S_PIN];
  wire logic bor_rst = filt_reg[WDRS_S_BOR];
  wire logic scan_rst = filt_reg[WDRS_S_SCAN];

  // A level change counts once stages two and three agree
  assign agree = ~(s2_reg ^ s3_reg);
  assign filt_next = (agree & s3_reg) | (~agree & filt_reg);
  // One tick per rising edge of the watchdog oscillator
  wire logic tick = filt_next[WDRS_S_OSC] && !filt_reg[WDRS_S_OSC];

  // Effective mode bits; the fuse forces reset-only mode
  wire logic wde_eff = ctrl_reg.dog_sysreset_enable || cause_reg.dog || fuse;
  wire logic ie_eff = ctrl_reg.irq_en && !fuse;
  wire logic active = wde_eff || ie_eff;
  wire logic [3:0] per_cur = {ctrl_reg.per_hi, ctrl_reg.per_lo};

  // Time-out detection and its outcome
  wire logic hit = tick && active && (cnt_reg == wdrs_limit(per_cur));
  wire logic irq_set = hit && ie_eff && !(wde_eff && ctrl_reg.irq_flag);
  wire logic dog_rst = hit && wde_eff && (!ie_eff || ctrl_reg.irq_flag);
  wire logic sys_evt = dog_rst || pin_rst || bor_rst || scan_rst;

  // Protected write handling
  wire logic unlocked = ctrl_reg.unlock;
  wire logic unlock_start = wr_ctrl && wd.unlock && wd.dog_sysreset_enable;
  wire logic unlock_end = unlocked && (unl_cnt_reg == WDRS_UNLOCK_LAST);
  wire logic wde_wr = unlocked ? wd.dog_sysreset_enable : (ctrl_reg.dog_sysreset_enable || wd.dog_sysreset_enable);
  wire logic [3:0] per_wr = unlocked ? {wd.per_hi, wd.per_lo} : per_cur;

  // Next control value
  always_comb begin
    ctrl_next = ctrl_reg;
    // Flag: set wins over write-one and vector clears
    ctrl_next.irq_flag = irq_set ||
      (ctrl_reg.irq_flag && !(wr_ctrl && wd.irq_flag) && !dog_vector_ack);
    if (wr_ctrl) begin
      // Software write of enable, reset enable and period
      ctrl_next.irq_en = wd.irq_en;
      ctrl_next.dog_sysreset_enable = wde_wr;
      ctrl_next.per_hi = per_wr[3];
      ctrl_next.per_lo = per_wr[2:0];
    end else if (dog_vector_ack && wde_eff) begin
      // Combined mode drops to reset-only when serviced
      ctrl_next.irq_en = 1'b0;
    end
    // Unlock window opens on write, closes on use or expiry
    if (unlock_start) begin
      ctrl_next.unlock = 1'b1;
    end else if (wr_ctrl || unlock_end) begin
      ctrl_next.unlock = 1'b0;
    end
    // Reset enable stays set while the cause flag or fuse holds it
    ctrl_next.dog_sysreset_enable = ctrl_next.dog_sysreset_enable || cause_reg.dog || fuse;
    if (sys_evt) begin
      // Any system reset returns set-up to defaults, keeping reset enable
      ctrl_next = WDRS_CTRL_RST;
      ctrl_next.dog_sysreset_enable = ctrl_reg.dog_sysreset_enable || dog_rst || fuse;
    end
  end

  // Unlock window counter
  always_comb begin
    unl_cnt_next = unl_cnt_reg;
    if (unlock_start) begin
      unl_cnt_next = WDRS_UNLOCK_CYCLES;
    end else if (unlocked && unl_cnt_reg != 3'h0) begin
      unl_cnt_next = unl_cnt_reg - 3'h1;
    end
  end

  // Next cause flags: hardware set wins over software zero
  always_comb begin
    cause_next = cause_reg;
    if (wr_cause) begin
      cause_next = cause_reg & wdrs_cause_t'(bus.wdata);
    end
    cause_next.scan = cause_next.scan || scan_rst;
    cause_next.dog = cause_next.dog || dog_rst;
    cause_next.brown = cause_next.brown || bor_rst;
    cause_next.pin = cause_next.pin || pin_rst;
    cause_next.pad = 3'h0;
  end

  // Watchdog counter
  always_comb begin
    cnt_next = cnt_reg;
    if (dog_restart || hit || sys_evt) begin
      cnt_next = '0;
    end else if (tick && active) begin
      cnt_next = cnt_reg + WDRS_CNT_W'(1);
    end
  end

  // Read data and interrupt request
  assign rdata_next = rd_ctrl ? {ctrl_reg.irq_flag, ie_eff, ctrl_reg.per_hi, ctrl_reg.unlock,
                      wde_eff, ctrl_reg.per_lo} : (rd_cause ? 8'(cause_reg) : 8'h00);
  assign irq_next = ctrl_next.irq_flag && ctrl_next.irq_en && !fuse
                    && cpu_global_irq_enable;

  // Pin synchronisers
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      filt_reg <= '0;
    end else if (ce) begin
      s1_reg <= {dog_always_on_fuse, scan_reset_in, brownout_in, pin_reset_in, dog_osc_in};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      filt_reg <= filt_next;
    end
  end

  // Control and counter state; power-on sets only the power-on flag
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_reg <= WDRS_CTRL_RST;
      cause_reg <= WDRS_CAUSE_POR;
      cnt_reg <= '0;
      unl_cnt_reg <= 3'h0;
    end else if (ce) begin
      ctrl_reg <= ctrl_next;
      cause_reg <= cause_next;
      cnt_reg <= cnt_next;
      unl_cnt_reg <= unl_cnt_next;
    end
  end

  // Output flops
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_reg <= 8'h00;
      irq_reg <= 1'b0;
      pulse_reg <= 1'b0;
    end else if (ce) begin
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
      pulse_reg <= dog_rst;
    end
  end

  assign rdata = rdata_reg;
  assign dog_irq = irq_reg;
  assign dog_sysreset_pulse = pulse_reg;
endmodule : wdrs_top

// ==== dv/testbench.sv ====
// Self-checking bench for the watchdog and reset cause block
`timescale 1ns/100ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value %s expected %0h seen %0h", n, e, g); end end
module testbench;
  import wdrs_pkg::*;
  logic clk = 0, rst = 1, osc = 0, glob = 1, ack = 0, rsr = 0, fuse = 0;
  logic [2:0] src = 3'h0;
  wdrs_bus_t bus = '0;
  wire [7:0] rdata;
  wire irq, pulse;
  int mismatches = 0, tests_run = 0, cyc = 0, n;
  wdrs_top wdrs_top_i (.clk(clk), .rst(rst), .ce(1'b1), .bus(bus), .rdata(rdata),
    .dog_osc_in(osc), .pin_reset_in(src[0]), .brownout_in(src[1]), .scan_reset_in(src[2]),
    .dog_always_on_fuse(fuse), .dog_restart(rsr), .cpu_global_irq_enable(glob),
    .dog_vector_ack(ack), .dog_irq(irq), .dog_sysreset_pulse(pulse));
  // Clock and hang limit
  initial forever #25 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 70000) begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk) bus.wr <= 1'b0;
  endtask : wr
  // Read, then compare the data of the following cycle
  task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string n);
    @(posedge clk) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk) bus.rd <= 1'b0;
    #1 `CHK(n, e, rdata)
  endtask : rchk
  // Restart the counter, then set control
  task automatic arm(input logic [7:0] v);
    @(posedge clk) rsr <= 1'b1;
    @(posedge clk) rsr <= 1'b0;
    wr(WDRS_CTRL_OFF, v);
  endtask : arm
  // One tick per four cycles until irq or pulse shows
  task automatic run(input logic want, input string n);
    int k;
    logic seen;
    seen = 1'b0;
    for (k = 0; k < 8400 && !seen; k++) begin
      @(posedge clk) osc <= k[1];
      #1 seen = want ? pulse === 1'b1 : irq === 1'b1;
    end
    `CHK(n, 1'b1, seen && (k + 1) / 4 inside {[2048:2050]})
  endtask : run
  task automatic vec;
    @(posedge clk) ack <= 1'b1;
    @(posedge clk) ack <= 1'b0;
    #1 `CHK("irq", 1'b0, irq)
  endtask : vec
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rchk(WDRS_CAUSE_OFF, 8'h01, "cause");
    rchk(WDRS_CTRL_OFF, 8'h00, "ctrl");
    rchk(8'h33, 8'h00, "unmapped");
    wr(WDRS_CAUSE_OFF, 8'h00);
    rchk(WDRS_CAUSE_OFF, 8'h00, "cause");
    $display("test reset done");
    wr(WDRS_CTRL_OFF, 8'h0D);
    rchk(WDRS_CTRL_OFF, 8'h08, "locked");
    wr(WDRS_CTRL_OFF, 8'h18);
    wr(WDRS_CTRL_OFF, 8'h01);
    rchk(WDRS_CTRL_OFF, 8'h01, "open");
    wr(WDRS_CTRL_OFF, 8'h18);
    rchk(WDRS_CTRL_OFF, 8'h19, "unlock");
    repeat (2) @(posedge clk);
    rchk(WDRS_CTRL_OFF, 8'h09, "relock");
    wr(WDRS_CTRL_OFF, 8'h00);
    rchk(WDRS_CTRL_OFF, 8'h09, "late");
    wr(WDRS_CTRL_OFF, 8'h18);
    wr(WDRS_CTRL_OFF, 8'h00);
    $display("test unlock done");
    arm(8'h40);
    run(1'b0, "irq time");
    rchk(WDRS_CTRL_OFF, 8'hC0, "flag");
    @(posedge clk) glob <= 1'b0;
    @(posedge clk) #1 `CHK("masked", 1'b0, irq)
    @(posedge clk) glob <= 1'b1;
    wr(WDRS_CTRL_OFF, 8'hC0);
    rchk(WDRS_CTRL_OFF, 8'h40, "w1c");
    run(1'b0, "irq again");
    vec();
    rchk(WDRS_CTRL_OFF, 8'h40, "vector");
    $display("test interrupt done");
    arm(8'h48);
    run(1'b0, "combined");
    vec();
    rchk(WDRS_CTRL_OFF, 8'h08, "combined vec");
    arm(8'h48);
    run(1'b0, "first");
    run(1'b1, "second");
    rchk(WDRS_CAUSE_OFF, 8'h08, "dog cause");
    wr(WDRS_CTRL_OFF, 8'h18);
    wr(WDRS_CTRL_OFF, 8'h00);
    rchk(WDRS_CTRL_OFF, 8'h08, "held");
    wr(WDRS_CAUSE_OFF, 8'h00);
    wr(WDRS_CTRL_OFF, 8'h18);
    wr(WDRS_CTRL_OFF, 8'h00);
    rchk(WDRS_CTRL_OFF, 8'h00, "off");
    $display("test combined done");
    for (n = 0; n < 3; n++) begin
      @(posedge clk) src <= 3'h1 << n;
      repeat (10) @(posedge clk);
      src <= 3'h0;
      repeat (6) @(posedge clk);
      rchk(WDRS_CAUSE_OFF, n == 2 ? 8'h10 : 8'h02 << n, "source");
      wr(WDRS_CAUSE_OFF, 8'h00);
    end
    $display("test sources done");
    @(posedge clk) fuse <= 1'b1;
    repeat (8) @(posedge clk);
    arm(8'h40);
    rchk(WDRS_CTRL_OFF, 8'h08, "fuse");
    run(1'b1, "fuse pulse");
    $display("test fuse done");
    report_and_stop();
  end
endmodule : testbench

// ==== dv/wdrs_sva.sv ====
// Port checker for the watchdog and reset cause block
`timescale 1ns/100ps
module wdrs_sva (
  input wire logic clk,
  input wire logic rst,
  input wire wdrs_pkg::wdrs_bus_t bus,
  input wire logic [7:0] rdata,
  input wire logic pin_reset_in,
  input wire logic brownout_in,
  input wire logic scan_reset_in,
  input wire logic dog_always_on_fuse,
  input wire logic cpu_global_irq_enable,
  input wire logic dog_vector_ack,
  input wire logic dog_irq,
  input wire logic dog_sysreset_pulse
);
  import wdrs_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Any reset source level
  wire src_any = pin_reset_in | brownout_in | scan_reset_in;
  // No second pulse for eight cycles
  sequence s_calm; !dog_sysreset_pulse [*8]; endsequence
  chk_rd_idle: assert property (!$past(bus.rd) |-> rdata == 8'h00)
    else $error("read data outside read slot");
  chk_pulse_once: assert property (dog_sysreset_pulse |=> s_calm)
    else $error("reset pulse too long");
  chk_irq_global: assert property (dog_irq |-> $past(cpu_global_irq_enable))
    else $error("irq without global enable");
  chk_ack_clear: assert property (dog_vector_ack |=> !dog_irq)
    else $error("irq kept after vector");
  chk_fuse_mute: assert property (dog_always_on_fuse [*8] |-> !dog_irq)
    else $error("irq with fuse set");
  chk_src_mute: assert property (src_any [*8] |-> !dog_irq)
    else $error("irq during reset event");
  chk_src_hold: assert property (src_any [*8] |-> !dog_sysreset_pulse)
    else $error("time-out during reset event");
  chk_rst_quiet: assert property (disable iff (1'b0)
    rst |=> rdata == 8'h00 && !dog_irq && !dog_sysreset_pulse)
    else $error("outputs active in reset");
endmodule : wdrs_sva
bind wdrs_top wdrs_sva wdrs_sva_i (.clk, .rst, .bus, .rdata, .pin_reset_in, .brownout_in,
  .scan_reset_in, .dog_always_on_fuse, .cpu_global_irq_enable, .dog_vector_ack, .dog_irq,
  .dog_sysreset_pulse);
